/* File: hw/dvs_consts.svh */
// Constants of the shared-variable lock block: offsets, fields, resets, times.
// Assumes inclusion by bare name from the design modules and the bench files.
`ifndef DVS_CONSTS_SVH
`define DVS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DVS_OFS_SEQ_LOCK 12'h000
`define DVS_OFS_PIC_LOCK 12'h004
`define DVS_OFS_SEQ_CTRL 12'h008
`define DVS_OFS_RUN_CTRL 12'h00c
`define DVS_OFS_SEQ_STAGE 12'h010
`define DVS_OFS_SEQ_ACTIVE 12'h014
`define DVS_OFS_PIC_INFO 12'h018
`define DVS_OFS_STATUS 12'h01c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DVS_CTRL_PENDING_BIT 0
`define DVS_CTRL_WP_BIT 1
`define DVS_CTRL_NODEF_BIT 2
`define DVS_RUN_BIT 0
`define DVS_ST_SEQ_HELD_BIT 0
`define DVS_ST_PIC_HELD_BIT 1
`define DVS_ST_OVERRUN_BIT 2

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define DVS_LOCK_FREE 16'h0000
`define DVS_HOST_CODE 16'h4242
`define DVS_DEC_CODE 16'h00a5
`define DVS_RST_WORD 16'h0000
`define DVS_SEQ_DEFAULT 16'h0000

// ----------------------------------------------------------------------
// Times in ns, clock period, and counts in clock cycles
// ----------------------------------------------------------------------
`define DVS_CLK_PERIOD_NS 100
`define DVS_SETTLE_NS 500
`define DVS_HOLD_MAX_NS 5000
`define DVS_SETTLE_CYC \
	((`DVS_SETTLE_NS + `DVS_CLK_PERIOD_NS - 1) / `DVS_CLK_PERIOD_NS)
`define DVS_HOLD_MAX_CYC (`DVS_HOLD_MAX_NS / `DVS_CLK_PERIOD_NS)
`define DVS_ACCESS_CYC 4
`define DVS_STRETCH_HALT 1
`define DVS_STRETCH_BLANK 2
`define DVS_STRETCH_ACTIVE 4

`endif

/* File: hw/dvs_pkg.sv */
// Types shared by the lock engine and the lock keeper.
// Assumes the constants header is on the include path.
`default_nettype none

package dvs_pkg;
	typedef enum logic [2:0] {
		DVS_IDLE = 3'b000,
		DVS_POLL = 3'b001,
		DVS_CLAIM = 3'b010,
		DVS_SETTLE = 3'b011,
		DVS_ACCESS = 3'b100,
		DVS_RELEASE = 3'b101
	} dvs_eng_state_t;

	typedef enum logic [1:0] {
		DVS_MODE_HALT = 2'b00,
		DVS_MODE_BLANK = 2'b01,
		DVS_MODE_ACTIVE = 2'b10
	} dvs_mode_t;
endpackage : dvs_pkg

`default_nettype wire

/* File: hw/dvs_lock_if.sv */
// Link between one lock word keeper and its claiming engine.
// Assumes both ends run on the same clock.
`default_nettype none

interface dvs_lock_if;
	logic [15:0] lock_q;
	logic req;
	logic lock_we;
	logic [15:0] lock_wd;
	logic granted;
	logic held;
	logic overrun;

	modport engine (
		input lock_q, req,
		output lock_we, lock_wd, granted, held, overrun
	);
	modport keeper (
		output lock_q, req,
		input lock_we, lock_wd, granted, held, overrun
	);
endinterface : dvs_lock_if

`default_nettype wire

/* File: hw/dvs_lock_engine.sv */
// Decoder-side claim, hold and release sequence for one lock word.
// Assumes the keeper lets a host write win over the engine's write.
`default_nettype none
`include "dvs_consts.svh"

module dvs_lock_engine
	import dvs_pkg::*;
#(
	parameter logic [15:0] OWN_CODE = `DVS_DEC_CODE,
	parameter int SETTLE_CYC = `DVS_SETTLE_CYC,
	parameter int HOLD_MAX_CYC = `DVS_HOLD_MAX_CYC,
	parameter int ACCESS_CYC = `DVS_ACCESS_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Stall while the bitstream buffer is empty
	input wire logic underflow,
	// Lock word link
	dvs_lock_if.engine lk
);
	typedef struct packed {
		dvs_eng_state_t st;
		logic [7:0] cnt;
		logic [7:0] hold;
		logic overrun;
	} dvs_eng_t;

	dvs_eng_t s_reg;
	dvs_eng_t s_next;
	logic settle_done;

	// Counters are eight bits wide, so longer times are refused
	if (OWN_CODE == `DVS_LOCK_FREE ||
			OWN_CODE == `DVS_HOST_CODE) begin : g_bad_code
		$error("engine code must be nonzero and not the host code");
	end
	if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
		$error("settle count out of range");
	end
	if (ACCESS_CYC < 1 || ACCESS_CYC > HOLD_MAX_CYC ||
			HOLD_MAX_CYC > 255) begin : g_bad_access
		$error("access count must fit the hold limit");
	end

	assign settle_done = (s_reg.cnt == 8'(SETTLE_CYC - 1));

	always_comb begin
		s_next = s_reg;
		lk.lock_we = 1'b0;
		lk.lock_wd = `DVS_LOCK_FREE;
		lk.granted = 1'b0;
		lk.held = (s_reg.st == DVS_ACCESS);
		lk.overrun = s_reg.overrun;
		// Hold time runs from the claim write and saturates at the limit
		if (s_reg.hold != 8'(HOLD_MAX_CYC - 1))
			s_next.hold = s_reg.hold + 8'h01;
		case (s_reg.st)
			DVS_IDLE: begin
				if (lk.req)
					s_next.st = DVS_POLL;
			end
			DVS_POLL: begin
				// Zero is free; host code or any other owner means wait
				if (lk.lock_q == `DVS_LOCK_FREE)
					s_next.st = DVS_CLAIM;
			end
			DVS_CLAIM: begin
				lk.lock_we = 1'b1;
				lk.lock_wd = OWN_CODE;
				s_next.st = DVS_SETTLE;
				s_next.hold = 8'h00;
				s_next.cnt = 8'h00;
			end
			DVS_SETTLE: begin
				s_next.cnt = s_reg.cnt + 8'h01;
				if (settle_done) begin
					s_next.cnt = 8'h00;
					// A host that wrote over us wins; we poll again
					if (lk.lock_q == OWN_CODE) begin
						s_next.st = DVS_ACCESS;
						lk.granted = 1'b1;
					end else begin
						s_next.st = DVS_POLL;
					end
				end
			end
			DVS_ACCESS: begin
				// An empty bitstream buffer stalls the access
				if (!underflow) begin
					s_next.cnt = s_reg.cnt + 8'h01;
					if (s_reg.cnt == 8'(ACCESS_CYC - 1))
						s_next.st = DVS_RELEASE;
				end else if (s_reg.hold == 8'(HOLD_MAX_CYC - 1)) begin
					s_next.overrun = 1'b1;
				end
			end
			DVS_RELEASE: begin
				lk.lock_we = 1'b1;
				lk.lock_wd = `DVS_LOCK_FREE;
				s_next.st = DVS_IDLE;
			end
			default: begin
				s_next.st = DVS_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{st: DVS_IDLE, cnt: 8'h00, hold: 8'h00,
				overrun: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : dvs_lock_engine

`default_nettype wire

/* File: hw/dvs_lock_top.sv */
// Shared-variable lock block: lock words, sequence control and APB slave.
// Assumes start-code events arrive as one-cycle pulses on pclk.
//
// Notes on behaviour
// - Zero lock word: group free, nobody touches variables, anyone may claim.
// - Lock holding 4242 hex: host owns group, decoder keeps off.
// - Owner releases a group by writing zero into its lock word.
// - Decoder holds a lock at most 5 us unless buffer underflows.
// - Sequence group claimed on sequence header, group start, sequence end.
// - Picture group claimed on group start and picture start.
// - On group start, pending bit set loads sequence values into settings.
// - Pending set on header unless write-protect, on end unless protect; the code gates the end case on nodef, not wp.
// - Host sequence values take effect only at next group-of-pictures header.
// - Acknowledge held low stretches host cycles; limit set by mode.
// - After reset both sequence lock and control word read zero.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`default_nettype none
`include "dvs_consts.svh"

module dvs_lock_top
	import dvs_pkg::*;
#(
	parameter int STRETCH_HALT = `DVS_STRETCH_HALT,
	parameter int STRETCH_BLANK = `DVS_STRETCH_BLANK,
	parameter int STRETCH_ACTIVE = `DVS_STRETCH_ACTIVE
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Host cycle extension, low while stretching
	output logic transfer_acknowledge,
	// Bitstream events, one-cycle pulses; underflow and active display are levels
	input wire logic seq_header_found,
	input wire logic group_start_found,
	input wire logic seq_end_found,
	input wire logic picture_start_found,
	input wire logic bitstream_underflow,
	input wire logic active_display,
	// Decoded header values
	input wire logic [15:0] seq_header_value,
	input wire logic [15:0] picture_header_value,
	// Settings taken over, one-cycle pulse
	output logic settings_loaded
);
	typedef struct packed {
		logic [1:0][15:0] lock;
		logic pending;
		logic wp;
		logic nodef;
		logic run;
		logic [15:0] stage;
		logic [15:0] active;
		logic [15:0] pic_info;
		logic [2:0] seq_job;
		logic pic_job;
		logic [7:0] wait_cnt;
		logic [31:0] rdata;
		logic loaded;
	} dvs_top_t;

	localparam int SEQ = 0;
	localparam int PIC = 1;
	localparam int JOB_HDR = 0;
	localparam int JOB_GOP = 1;
	localparam int JOB_END = 2;

	dvs_top_t s_reg;
	dvs_top_t s_next;
	dvs_lock_if lk [2] ();
	logic [1:0] lock_we;
	logic [1:0][15:0] lock_wd;
	logic [1:0] granted;
	logic [1:0] held;
	logic [1:0] overrun;
	logic access;
	logic wr_fire;
	logic addr_ok;
	logic [7:0] stretch_lim;
	dvs_mode_t mode;

	// A zero limit would let pready rise in the first access cycle
	if (STRETCH_HALT < 1 || STRETCH_BLANK < 1 ||
			STRETCH_ACTIVE < 1) begin : g_bad_min
		$error("stretch counts must be at least one cycle");
	end
	if (STRETCH_HALT > 255 || STRETCH_BLANK > 255 ||
			STRETCH_ACTIVE > 255) begin : g_bad_max
		$error("stretch counts must fit eight bits");
	end

	// ----------------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------------
	function automatic logic dvs_is_mapped(input logic [11:0] a);
		case (a)
			`DVS_OFS_SEQ_LOCK, `DVS_OFS_PIC_LOCK, `DVS_OFS_SEQ_CTRL,
			`DVS_OFS_RUN_CTRL, `DVS_OFS_SEQ_STAGE, `DVS_OFS_SEQ_ACTIVE,
			`DVS_OFS_PIC_INFO, `DVS_OFS_STATUS: dvs_is_mapped = 1'b1;
			default: dvs_is_mapped = 1'b0;
		endcase
	endfunction : dvs_is_mapped

	function automatic logic [31:0] dvs_read(input logic [11:0] a,
			input dvs_top_t s, input logic [1:0] h, input logic [1:0] o);
		dvs_read = 32'h0000_0000;
		case (a)
			`DVS_OFS_SEQ_LOCK: dvs_read[15:0] = s.lock[SEQ];
			`DVS_OFS_PIC_LOCK: dvs_read[15:0] = s.lock[PIC];
			`DVS_OFS_SEQ_CTRL: begin
				dvs_read[`DVS_CTRL_PENDING_BIT] = s.pending;
				dvs_read[`DVS_CTRL_WP_BIT] = s.wp;
				dvs_read[`DVS_CTRL_NODEF_BIT] = s.nodef;
			end
			`DVS_OFS_RUN_CTRL: dvs_read[`DVS_RUN_BIT] = s.run;
			`DVS_OFS_SEQ_STAGE: dvs_read[15:0] = s.stage;
			`DVS_OFS_SEQ_ACTIVE: dvs_read[15:0] = s.active;
			`DVS_OFS_PIC_INFO: dvs_read[15:0] = s.pic_info;
			`DVS_OFS_STATUS: begin
				dvs_read[`DVS_ST_SEQ_HELD_BIT] = h[SEQ];
				dvs_read[`DVS_ST_PIC_HELD_BIT] = h[PIC];
				dvs_read[`DVS_ST_OVERRUN_BIT] = |o;
			end
			default: dvs_read = 32'h0000_0000;
		endcase
	endfunction : dvs_read

	// ----------------------------------------------------------------------
	// Claiming engines, one for each group
	// ----------------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_eng
		assign lk[g].lock_q = s_reg.lock[g];
		assign lock_we[g] = lk[g].lock_we;
		assign lock_wd[g] = lk[g].lock_wd;
		assign granted[g] = lk[g].granted;
		assign held[g] = lk[g].held;
		assign overrun[g] = lk[g].overrun;

		dvs_lock_engine u_eng (
			.pclk(pclk),
			.presetn(presetn),
			.underflow(bitstream_underflow),
			.lk(lk[g])
		);
	end
	assign lk[SEQ].req = |s_reg.seq_job;
	assign lk[PIC].req = s_reg.pic_job;

	// ----------------------------------------------------------------------
	// Bus handshake and cycle stretching
	// ----------------------------------------------------------------------
	always_comb begin
		if (!s_reg.run)
			mode = DVS_MODE_HALT;
		else if (active_display)
			mode = DVS_MODE_ACTIVE;
		else
			mode = DVS_MODE_BLANK;
		case (mode)
			DVS_MODE_HALT: stretch_lim = 8'(STRETCH_HALT);
			DVS_MODE_BLANK: stretch_lim = 8'(STRETCH_BLANK);
			DVS_MODE_ACTIVE: stretch_lim = 8'(STRETCH_ACTIVE);
			default: stretch_lim = 8'(STRETCH_HALT);
		endcase
	end

	assign access = psel & penable;
	assign pready = access & (s_reg.wait_cnt >= stretch_lim);
	assign transfer_acknowledge = pready;
	assign addr_ok = dvs_is_mapped(paddr);
	assign pslverr = pready & ~addr_ok;
	assign wr_fire = pready & pwrite & addr_ok & pstrb[0] & pstrb[1];
	assign prdata = s_reg.rdata;
	assign settings_loaded = s_reg.loaded;

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb begin
		logic pend;
		logic [15:0] stg;
		pend = 1'b0;
		stg = 16'h0000;
		s_next = s_reg;
		s_next.loaded = 1'b0;

		if (access && !pready)
			s_next.wait_cnt = s_reg.wait_cnt + 8'h01;
		else
			s_next.wait_cnt = 8'h00;
		// Read data is refreshed while the access is stretched
		if (psel && !pready)
			s_next.rdata = dvs_read(paddr, s_reg, held, overrun);

		// Engine writes first; a host write in the same cycle overrides
		for (int g = 0; g < 2; g++) begin
			if (lock_we[g])
				s_next.lock[g] = lock_wd[g];
		end
		if (wr_fire) begin
			case (paddr)
				`DVS_OFS_SEQ_LOCK: s_next.lock[SEQ] = pwdata[15:0];
				`DVS_OFS_PIC_LOCK: s_next.lock[PIC] = pwdata[15:0];
				`DVS_OFS_SEQ_CTRL: begin
					// A host zero on pending is not trusted to clear it
					s_next.pending = s_reg.pending |
						pwdata[`DVS_CTRL_PENDING_BIT];
					s_next.wp = pwdata[`DVS_CTRL_WP_BIT];
					s_next.nodef = pwdata[`DVS_CTRL_NODEF_BIT];
				end
				`DVS_OFS_RUN_CTRL: s_next.run = pwdata[`DVS_RUN_BIT];
				`DVS_OFS_SEQ_STAGE: s_next.stage = pwdata[15:0];
				default: s_next.run = s_reg.run;
			endcase
		end

		// Events queue a claim; a new event beats the clear at grant
		if (granted[SEQ])
			s_next.seq_job = 3'b000;
		if (granted[PIC])
			s_next.pic_job = 1'b0;
		if (s_reg.run) begin
			if (seq_header_found)
				s_next.seq_job[JOB_HDR] = 1'b1;
			if (group_start_found)
				s_next.seq_job[JOB_GOP] = 1'b1;
			if (seq_end_found)
				s_next.seq_job[JOB_END] = 1'b1;
			if (group_start_found || picture_start_found)
				s_next.pic_job = 1'b1;
		end

		// Sequence group work, done only while the lock is ours
		pend = s_next.pending;
		stg = s_next.stage;
		if (granted[SEQ]) begin
			if (s_reg.seq_job[JOB_HDR] && !s_reg.wp) begin
				stg = seq_header_value;
				pend = 1'b1;
			end
			if (s_reg.seq_job[JOB_END] && !s_reg.nodef) begin
				stg = `DVS_SEQ_DEFAULT;
				pend = 1'b1;
			end
			// Host values wait here for the next group start
			if (s_reg.seq_job[JOB_GOP] && pend) begin
				s_next.active = stg;
				s_next.loaded = 1'b1;
				pend = 1'b0;
			end
		end
		s_next.pending = pend;
		s_next.stage = stg;

		// Picture group work
		if (granted[PIC])
			s_next.pic_info = picture_header_value;
	end

	// ----------------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.lock <= {`DVS_RST_WORD, `DVS_RST_WORD};
			s_reg.stage <= `DVS_RST_WORD;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : dvs_lock_top

`default_nettype wire

/* File: dv/dvs_lock_monitor.sv */
// Checker for the lock block's host port and load pulse.
// Assumes it is bound into dvs_lock_top and sees only its ports.
`default_nettype none

module dvs_lock_monitor
	import dvs_pkg::*;
#(
	parameter int STRETCH_HALT = 1,
	parameter int STRETCH_BLANK = 2,
	parameter int STRETCH_ACTIVE = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic transfer_acknowledge,
	// Bitstream side
	input wire logic seq_header_found,
	input wire logic group_start_found,
	input wire logic seq_end_found,
	input wire logic picture_start_found,
	input wire logic bitstream_underflow,
	input wire logic active_display,
	input wire logic [15:0] seq_header_value,
	input wire logic [15:0] picture_header_value,
	input wire logic settings_loaded
);
	// ----------------------------------------------------------------
	// Helper state
	// ----------------------------------------------------------------
	// Run bit mirrored from completed writes, so the limit is known
	logic run_q;
	logic [7:0] wait_cnt;
	logic [15:0] gop_age;
	logic [7:0] lim;
	logic acc;
	assign acc = psel && penable;
	assign lim = !run_q ? 8'(STRETCH_HALT) :
		active_display ? 8'(STRETCH_ACTIVE) : 8'(STRETCH_BLANK);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
			wait_cnt <= 8'h00;
			gop_age <= 16'hffff;
		end else begin
			if (acc && pready && pwrite && paddr == 12'h00c &&
				pstrb[1:0] == 2'b11)
				run_q <= pwdata[0];
			wait_cnt <= (acc && !pready) ? wait_cnt + 8'h01 : 8'h00;
			if (group_start_found)
				gop_age <= 16'h0000;
			else if (gop_age != 16'hffff)
				gop_age <= gop_age + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	ack_follows_a: assert property (
		transfer_acknowledge |-> pready ##1 !transfer_acknowledge)
		else $error("ack not a single pulse");
	stretch_len_a: assert property (
		acc |-> pready == (wait_cnt >= lim)) else $error("bad stretch");
	first_access_a: assert property (
		psel && !penable ##1 acc |-> !pready) else $error("early ready");
	idle_quiet_a: assert property (
		!acc |-> !pready && !pslverr) else $error("ready when idle");
	unmapped_a: assert property (
		acc && pready && paddr > 12'h01c |-> pslverr &&
		prdata == 32'h0000_0000) else $error("unmapped accepted");
	mapped_ok_a: assert property (
		acc && pready && paddr <= 12'h01c && paddr[1:0] == 2'b00
		|-> !pslverr) else $error("mapped refused");
	load_pulse_a: assert property (
		settings_loaded |=> !settings_loaded) else $error("long load");
	load_cause_a: assert property (
		settings_loaded |-> gop_age < 16'd2000) else $error("stray load");

	cov_load: cover property (settings_loaded);
	cov_err: cover property (pslverr);
	cov_slow: cover property (pready && wait_cnt == 8'(STRETCH_ACTIVE));
endmodule : dvs_lock_monitor

bind dvs_lock_top dvs_lock_monitor #(.STRETCH_HALT(STRETCH_HALT),
	.STRETCH_BLANK(STRETCH_BLANK), .STRETCH_ACTIVE(STRETCH_ACTIVE))
	i_dvs_lock_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.transfer_acknowledge(transfer_acknowledge),
	.seq_header_found(seq_header_found),
	.group_start_found(group_start_found), .seq_end_found(seq_end_found),
	.picture_start_found(picture_start_found),
	.bitstream_underflow(bitstream_underflow),
	.active_display(active_display), .seq_header_value(seq_header_value),
	.picture_header_value(picture_header_value),
	.settings_loaded(settings_loaded));

`default_nettype wire

/* File: dv/dvs_host_model.sv */
// Host processor model: APB master with lock claim and release.
// Assumes one clock; every request starts just after a rising edge.
`default_nettype none
`include "dvs_consts.svh"

module dvs_host_model (
	// Clock
	input wire logic pclk,
	// APB master
	output var logic psel,
	output var logic penable,
	output var logic pwrite,
	output var logic [11:0] paddr,
	output var logic [31:0] pwdata,
	output var logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [31:0] prdata,
	// Set when a wait runs out
	output var logic stuck
);
	logic [33:0] expq[$];
	logic [31:0] last_rd;
	int held;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hf;
		stuck = 1'b0;
		held = 0;
	end

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s, input logic [33:0] e);
		int i;
		if (!w)
			expq.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 64)
			stuck <= 1'b1;
		last_rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	// Only one lock at a time, so a held count above one is a fault
	task automatic claim(input logic [11:0] a);
		int n;
		for (n = 0; n < 50; n++) begin
			xfer(1'b0, a, 32'h0, 4'hf, 34'h0);
			if (last_rd[15:0] == `DVS_LOCK_FREE) begin
				xfer(1'b1, a, {16'h0000, `DVS_HOST_CODE}, 4'hf, 34'h0);
				repeat (6) @(posedge pclk);
				xfer(1'b0, a, 32'h0, 4'hf, 34'h0);
				if (last_rd[15:0] == `DVS_HOST_CODE)
					break;
			end
		end
		held++;
		if (n == 50 || held > 1)
			stuck <= 1'b1;
	endtask : claim

	// Released about 8 us after the claim write, beyond the 5 us hold budget
	task automatic release_lock(input logic [11:0] a);
		xfer(1'b1, a, 32'h0, 4'hf, 34'h0);
		held--;
	endtask : release_lock
endmodule : dvs_host_model

`default_nettype wire

/* File: dv/dvs_testbench.sv */
// Self-checking bench for the lock block.
// Assumes the host model is the only APB master.
`default_nettype none
`include "dvs_consts.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] SLK = `DVS_OFS_SEQ_LOCK;
	localparam logic [11:0] CTL = `DVS_OFS_SEQ_CTRL;
	localparam logic [11:0] STG = `DVS_OFS_SEQ_STAGE;
	localparam logic [11:0] ACT = `DVS_OFS_SEQ_ACTIVE;
	localparam logic [3:0] HDR = 4'b1000;
	localparam logic [3:0] GOP = 4'b0100;
	localparam logic [3:0] SEND = 4'b0010;
	localparam logic [3:0] PIC = 4'b0001;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic ack, loaded, underflow, act_disp, stuck, pend;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v, stg, act;
	logic [3:0] pstrb, evt;
	logic [15:0] hdr, pic;
	logic [33:0] e;
	logic [31:0] seed = 32'h0000_b031;
	int error_cnt = 0;
	int comparisons = 0;
	int loads = 0;
	int k, w;

	dvs_lock_top i_dvs_lock_top (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .transfer_acknowledge(ack),
		.seq_header_found(evt[3]), .group_start_found(evt[2]),
		.seq_end_found(evt[1]), .picture_start_found(evt[0]),
		.bitstream_underflow(underflow), .active_display(act_disp),
		.seq_header_value(hdr), .picture_header_value(pic),
		.settings_loaded(loaded));
	dvs_host_model i_dvs_host_model (.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .stuck(stuck));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return {16'h0000, seed[15:0]};
	endfunction : rnd

	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask : chk

	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic er);
		i_dvs_host_model.xfer(1'b0, a, 32'h0, 4'hf, {1'b1, er, x});
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_dvs_host_model.xfer(1'b1, a, d, 4'hf, 34'h0);
	endtask : wr

	task automatic fire(input logic [3:0] m);
		evt <= m;
		@(posedge pclk);
		evt <= 4'h0;
		repeat (30) @(posedge pclk);
	endtask : fire

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// Result watcher
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		if (loaded === 1'b1)
			loads++;
		if (psel && penable && pready === 1'b1 && !pwrite &&
			i_dvs_host_model.expq.size() != 0) begin
			e = i_dvs_host_model.expq.pop_front();
			if (e[33]) begin
				chk("read data", prdata, e[31:0]);
				chk("slave error", {31'h0, pslverr}, {31'h0, e[32]});
			end
		end
	end

	initial begin
		for (w = 0; w < 30000 && stuck !== 1'b1; w++)
			@(posedge pclk);
		error_cnt++;
		$display("[FAIL] completion expected done seen hang");
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		evt = 4'h0;
		underflow = 1'b0;
		act_disp = 1'b0;
		hdr = 16'h0000;
		pic = 16'h0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(SLK, 32'h0, 1'b0);
		rd(`DVS_OFS_PIC_LOCK, 32'h0, 1'b0);
		rd(CTL, 32'h0, 1'b0);
		rd(12'h020, 32'h0, 1'b1);
		$display("reset test done");
		fire(GOP);
		i_dvs_host_model.claim(SLK);
		rd(SLK, {16'h0, `DVS_HOST_CODE}, 1'b0);
		v = rnd();
		wr(STG, v);
		i_dvs_host_model.xfer(1'b1, STG, ~v, 4'b1100, 34'h0);
		rd(STG, v, 1'b0);
		wr(CTL, 32'h1);
		wr(`DVS_OFS_RUN_CTRL, 32'h1);
		fire(GOP);
		rd(SLK, {16'h0, `DVS_HOST_CODE}, 1'b0);
		rd(`DVS_OFS_STATUS, 32'h0, 1'b0);
		chk("early load", loads, 0);
		i_dvs_host_model.release_lock(SLK);
		repeat (30) @(posedge pclk);
		chk("load count", loads, 1);
		rd(ACT, v, 1'b0);
		rd(CTL, 32'h0, 1'b0);
		rd(SLK, 32'h0, 1'b0);
		$display("host lock test done");
		act = v;
		stg = v;
		pend = 1'b0;
		for (k = 0; k < 4; k++) begin
			act_disp <= k[0];
			wr(CTL, {29'h0, k[1:0], 1'b0});
			v = rnd();
			hdr <= v[15:0];
			fire(HDR);
			if (!k[0]) begin
				stg = v;
				pend = 1'b1;
			end
			rd(STG, stg, 1'b0);
			rd(CTL, {29'h0, k[1:0], pend}, 1'b0);
			fire(SEND);
			if (!k[1]) begin
				stg = 32'h0;
				pend = 1'b1;
			end
			v = rnd();
			pic <= v[15:0];
			fire(GOP);
			if (pend)
				act = stg;
			pend = 1'b0;
			rd(ACT, act, 1'b0);
			rd(CTL, {29'h0, k[1:0], 1'b0}, 1'b0);
			rd(`DVS_OFS_PIC_INFO, v, 1'b0);
		end
		v = rnd();
		pic <= v[15:0];
		fire(PIC);
		rd(`DVS_OFS_PIC_INFO, v, 1'b0);
		rd(`DVS_OFS_STATUS, 32'h0, 1'b0);
		chk("load total", loads, 4);
		$display("bitstream test done");
		// A stalled hold past the limit must show as a sticky overrun
		underflow <= 1'b1;
		fire(PIC);
		repeat (50) @(posedge pclk);
		rd(`DVS_OFS_STATUS, 32'h0000_0006, 1'b0);
		underflow <= 1'b0;
		repeat (10) @(posedge pclk);
		rd(`DVS_OFS_STATUS, 32'h0000_0004, 1'b0);
		rd(`DVS_OFS_PIC_LOCK, 32'h0, 1'b0);
		$display("underflow test done");
		wrap_up();
	end
endmodule : testbench

`default_nettype wire
